//--- include/tmec_regs.vh
// register map, field positions and reset values of the timer/event counters
//
// Contract
// - system reset loads each mode register with 00H: stopped, match mode, output off
// - count enable bit 7 at 0 clears and stops counter; 1 starts counting
// - mode bit 6 at 0 restarts on match; 1 selects free-running PWM
// - preset bits 3,2: 00 no change, 01 clear, 10 set, 11 prohibited
// - preset bits are write-only and read back as 0
// - preset bits act only outside PWM mode, ignored in PWM mode
// - bit 1 enables toggle on match, or selects active-low level in PWM
// - output enable bit 0 at 0 forces output low; 1 passes flip-flop
// - in PWM mode clearing count enable drives output inactive
// - mode, preset, level and enable bits reach the pin regardless of counting
// - direction registers reset to all ones; 0 drives pin, 1 is input
// - interval mode match clears counter to 0, keeps counting, raises request
// - low three bits of clock select register choose the count clock
// - interval period is compare value plus one count clock periods
// - event mode counts each selected edge of the event input pin
// - every event mode match clears counter and raises the request
// - PWM match drives output inactive and raises no request
// - counter advances on each tick of the selected count clock: a prescaler tap or the selected event pin edge
`ifndef TMEC_REGS_VH
`define TMEC_REGS_VH

// -------------------------------------------------------------------------
// register indices, byte address is four times the index
// -------------------------------------------------------------------------
`define TMEC_IDX_PORT3_DIR   16'hff23
`define TMEC_IDX_MODE1       16'hff43
`define TMEC_IDX_MODE0       16'hff6b
`define TMEC_IDX_CLKSEL0     16'hff6a
`define TMEC_IDX_CLKSEL1     16'hff8c
`define TMEC_IDX_PORT1_DIR   16'hff21
`define TMEC_IDX_PORT1_LATCH 16'hff01
`define TMEC_IDX_PORT3_LATCH 16'hff03
`define TMEC_IDX_CMP0        16'hff10
`define TMEC_IDX_CMP1        16'hff11
`define TMEC_IDX_COUNT0      16'hff12
`define TMEC_IDX_COUNT1      16'hff13

// -------------------------------------------------------------------------
// mode control fields
// -------------------------------------------------------------------------
`define TMEC_BIT_CE       7
`define TMEC_BIT_PWM      6
`define TMEC_BIT_PSET     3
`define TMEC_BIT_PCLR     2
`define TMEC_BIT_LVL      1
`define TMEC_BIT_OE       0
`define TMEC_MODE_KEEP    8'hc3
`define TMEC_MODE_RST     8'h00
`define TMEC_DIR_RST      8'hff
`define TMEC_DIR3_RST     4'hf
`define TMEC_DIR3_FILL    4'hf

// -------------------------------------------------------------------------
// clock select codes and prescaler tap shifts
// -------------------------------------------------------------------------
`define TMEC_SEL_FALL     3'h0
`define TMEC_SEL_RISE     3'h1
`define TMEC_TAP_SEL2     4'h0
`define TMEC_TAP_SEL3     4'h1
`define TMEC_TAP0_SEL4    4'h2
`define TMEC_TAP1_SEL4    4'h4
`define TMEC_TAP_SEL5     4'h6
`define TMEC_TAP_SEL6     4'h8
`define TMEC_TAP0_SEL7    4'hd
`define TMEC_TAP1_SEL7    4'hc
`define TMEC_PRESC_W      13

`endif

//--- core/tmec_tick.v
// count clock selector: prescaler taps or event pin edges to one tick
`timescale 1ns/1ps
`include "tmec_regs.vh"
module tmec_tick
#(
    parameter CH = 0
)
(
    // clock and reset
    input  wire                     pclk,
    input  wire                     presetn,
    // prescaler and selection
    input  wire [`TMEC_PRESC_W-1:0] presc,
    input  wire [2:0]               sel,
    // event pin
    input  wire                     pin,
    // count enable pulse
    output wire                     tick
);

    // -------------------------------------------------------------------------
    // tap shift per code, the two channels differ in codes 4 and 7
    // -------------------------------------------------------------------------
    function [3:0] tap_shift;
        input [2:0] s;
        begin
            case (s)
                3'h2:    tap_shift = `TMEC_TAP_SEL2;
                3'h3:    tap_shift = `TMEC_TAP_SEL3;
                3'h4:    tap_shift = (CH == 0) ? `TMEC_TAP0_SEL4
                                               : `TMEC_TAP1_SEL4;
                3'h5:    tap_shift = `TMEC_TAP_SEL5;
                3'h6:    tap_shift = `TMEC_TAP_SEL6;
                default: tap_shift = (CH == 0) ? `TMEC_TAP0_SEL7
                                               : `TMEC_TAP1_SEL7;
            endcase
        end
    endfunction

    reg                      pin_q;
    wire [`TMEC_PRESC_W-1:0] mask;
    wire                     tap_hit;
    wire                     edge_hit;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_q <= 1'b1; // idle pin is high, so no false edge
        else
            pin_q <= pin;
    end

    // one-cycle pulse once per divided period; shift 0 fires every cycle
    assign mask     = (13'h0001 << tap_shift(sel)) - 13'h0001;
    assign tap_hit  = ((presc & mask) == mask);
    assign edge_hit = (sel == `TMEC_SEL_RISE) ? (pin & ~pin_q)
                                               : (~pin & pin_q);
    assign tick = (sel[2:1] == 2'b00) ? edge_hit : tap_hit;

endmodule // tmec_tick

//--- core/tmec_top.v
// two 8-bit timer/event counters with apb registers and shared port pins
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tmec_regs.vh"
module tmec_top
(
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [17:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // port 1 pins, bit 7 shared with timer 0
    input  wire [7:0]  port1_in,
    output reg  [7:0]  port1_out_q,
    output reg  [7:0]  port1_oe_q,
    // port 3 pins, bit 3 shared with timer 1
    input  wire [3:0]  port3_in,
    output reg  [3:0]  port3_out_q,
    output reg  [3:0]  port3_oe_q,
    // match interrupt requests
    output reg  [1:0]  match_irq_q
);

    // -------------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------------
    reg  [`TMEC_PRESC_W-1:0] presc_q;
    reg  [7:0]               mode0_q;
    reg  [7:0]               mode1_q;
    reg  [2:0]               clksel0_q;
    reg  [2:0]               clksel1_q;
    reg  [7:0]               cmp0_q;
    reg  [7:0]               cmp1_q;
    reg  [7:0]               port1_dir_q;
    reg  [3:0]               port3_dir_q;
    reg  [7:0]               port1_latch_q;
    reg  [3:0]               port3_latch_q;
    reg  [7:0]               rd_d;
    reg                      hit_d;
    wire [15:0]              idx;
    wire                     setup;
    wire                     wr_en;
    wire [7:0]               wbyte;
    wire [15:0]              mode_all;
    wire [5:0]               clksel_all;
    wire [15:0]              cmp_all;
    wire [15:0]              cnt_all;
    wire [1:0]               ev_pin;
    wire [1:0]               mode_wr;
    wire [1:0]               tout_all;
    wire [1:0]               irq_all;

    // -------------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------------
    function wr_to;
        input [15:0] a;
        input [15:0] r;
        input        en;
        begin
            wr_to = en & (a == r);
        end
    endfunction

    // bits 5..2 are never stored, so they read as zero
    function [7:0] mode_rd;
        input [7:0] m;
        begin
            mode_rd = m & `TMEC_MODE_KEEP;
        end
    endfunction

    assign idx   = paddr[17:2];
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite;
    assign wbyte = pwdata[7:0];

    always @*
    begin
        rd_d  = 8'h00;
        hit_d = 1'b1;
        case (idx)
            `TMEC_IDX_MODE0:       rd_d = mode_rd(mode0_q);
            `TMEC_IDX_MODE1:       rd_d = mode_rd(mode1_q);
            `TMEC_IDX_CLKSEL0:     rd_d = {5'h00, clksel0_q};
            `TMEC_IDX_CLKSEL1:     rd_d = {5'h00, clksel1_q};
            `TMEC_IDX_CMP0:        rd_d = cmp0_q;
            `TMEC_IDX_CMP1:        rd_d = cmp1_q;
            `TMEC_IDX_COUNT0:      rd_d = cnt_all[7:0];
            `TMEC_IDX_COUNT1:      rd_d = cnt_all[15:8];
            `TMEC_IDX_PORT1_DIR:   rd_d = port1_dir_q;
            `TMEC_IDX_PORT3_DIR:   rd_d = {`TMEC_DIR3_FILL, port3_dir_q};
            `TMEC_IDX_PORT1_LATCH: rd_d = port1_latch_q;
            `TMEC_IDX_PORT3_LATCH: rd_d = {4'h0, port3_latch_q};
            default:               hit_d = 1'b0;
        endcase
    end

    // answer is prepared in the setup cycle, so every access has no wait
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_d};
            pready  <= 1'b1;
            pslverr <= ~hit_d;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // software registers
    // -------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode0_q       <= `TMEC_MODE_RST;
            mode1_q       <= `TMEC_MODE_RST;
            clksel0_q     <= 3'h0;
            clksel1_q     <= 3'h0;
            cmp0_q        <= 8'h00;
            cmp1_q        <= 8'h00;
            port1_dir_q   <= `TMEC_DIR_RST;
            port3_dir_q   <= `TMEC_DIR3_RST;
            port1_latch_q <= 8'h00;
            port3_latch_q <= 4'h0;
        end
        else
        begin
            // preset bits are pulses, not stored
            if (mode_wr[0])
                mode0_q <= wbyte & `TMEC_MODE_KEEP;
            if (mode_wr[1])
                mode1_q <= wbyte & `TMEC_MODE_KEEP;
            if (wr_to(idx, `TMEC_IDX_CLKSEL0, wr_en))
                clksel0_q <= wbyte[2:0];
            if (wr_to(idx, `TMEC_IDX_CLKSEL1, wr_en))
                clksel1_q <= wbyte[2:0];
            if (wr_to(idx, `TMEC_IDX_CMP0, wr_en))
                cmp0_q <= wbyte;
            if (wr_to(idx, `TMEC_IDX_CMP1, wr_en))
                cmp1_q <= wbyte;
            if (wr_to(idx, `TMEC_IDX_PORT1_DIR, wr_en))
                port1_dir_q <= wbyte;
            if (wr_to(idx, `TMEC_IDX_PORT3_DIR, wr_en))
                port3_dir_q <= wbyte[3:0];
            if (wr_to(idx, `TMEC_IDX_PORT1_LATCH, wr_en))
                port1_latch_q <= wbyte;
            if (wr_to(idx, `TMEC_IDX_PORT3_LATCH, wr_en))
                port3_latch_q <= wbyte[3:0];
        end
    end

    assign mode_wr[0] = wr_to(idx, `TMEC_IDX_MODE0, wr_en);
    assign mode_wr[1] = wr_to(idx, `TMEC_IDX_MODE1, wr_en);

    // -------------------------------------------------------------------------
    // free-running prescaler shared by both channels
    // -------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_q <= 13'h0000;
        else
            presc_q <= presc_q + 13'h0001;
    end

    assign mode_all   = {mode1_q, mode0_q};
    assign clksel_all = {clksel1_q, clksel0_q};
    assign cmp_all    = {cmp1_q, cmp0_q};
    assign ev_pin     = {port3_in[3], port1_in[7]};

    // -------------------------------------------------------------------------
    // counter channels
    // -------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_ch
            reg  [7:0] cnt_q;
            reg  [7:0] cmp_act_q;
            reg        tff_q;
            reg        pwm_ff_q;
            wire       tick;
            wire       ce;
            wire       pwm;
            wire       lvl;
            wire       oe;
            wire [7:0] cmp;
            wire [7:0] cnt_inc;
            wire       wrap;
            wire [7:0] cmp_eff;
            wire       match;
            wire       p_set;
            wire       p_clr;

            tmec_tick #(
                .CH      (g)
            ) u_tick (
                .pclk    (pclk),
                .presetn (presetn),
                .presc   (presc_q),
                .sel     (clksel_all[3*g+:3]),
                .pin     (ev_pin[g]),
                .tick    (tick)
            );

            assign ce      = mode_all[8*g+`TMEC_BIT_CE];
            assign pwm     = mode_all[8*g+`TMEC_BIT_PWM];
            assign lvl     = mode_all[8*g+`TMEC_BIT_LVL];
            assign oe      = mode_all[8*g+`TMEC_BIT_OE];
            assign cmp     = cmp_all[8*g+:8];
            assign cnt_inc = cnt_q + 8'h01;
            assign wrap    = (cnt_q == 8'hff);
            // a new duty value is taken at overflow, never mid-period
            assign cmp_eff = wrap ? cmp : cmp_act_q;
            assign match   = ce & tick & ~pwm & (cnt_q == cmp);
            // 11 is prohibited and does nothing
            assign p_set = mode_wr[g] & ~wbyte[`TMEC_BIT_PWM]
                         & wbyte[`TMEC_BIT_PSET] & ~wbyte[`TMEC_BIT_PCLR];
            assign p_clr = mode_wr[g] & ~wbyte[`TMEC_BIT_PWM]
                         & ~wbyte[`TMEC_BIT_PSET] & wbyte[`TMEC_BIT_PCLR];

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt_q     <= 8'h00;
                    cmp_act_q <= 8'h00;
                    pwm_ff_q  <= 1'b0;
                end
                else if (!ce)
                begin
                    cnt_q     <= 8'h00;
                    cmp_act_q <= cmp;
                    pwm_ff_q  <= 1'b0;
                end
                else if (tick)
                begin
                    if (!pwm)
                    begin
                        cnt_q <= (cnt_q == cmp) ? 8'h00 : cnt_inc;
                    end
                    else
                    begin
                        cnt_q <= cnt_inc;
                        if (wrap)
                            cmp_act_q <= cmp;
                        if (cnt_inc == cmp_eff)
                            pwm_ff_q <= 1'b0;
                        else if (wrap)
                            pwm_ff_q <= 1'b1;
                    end
                end
                else if (!pwm)
                begin
                    cmp_act_q <= cmp;
                end
            end

            // timer flip-flop: preset write beats a toggle in the same cycle
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    tff_q <= 1'b0;
                else if (p_set)
                    tff_q <= 1'b1;
                else if (p_clr)
                    tff_q <= 1'b0;
                else if (match & lvl)
                    tff_q <= ~tff_q;
            end

            assign tout_all[g] = oe & (pwm ? (pwm_ff_q ^ lvl) : tff_q);
            assign irq_all[g]  = match;
            assign cnt_all[8*g+:8] = cnt_q;
        end
    endgenerate

    // -------------------------------------------------------------------------
    // pins and requests, all registered
    // -------------------------------------------------------------------------
    // the latch is or-ed in, so software keeps it 0 for timer output
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port1_out_q <= 8'h00;
            port1_oe_q  <= 8'h00;
            port3_out_q <= 4'h0;
            port3_oe_q  <= 4'h0;
            match_irq_q <= 2'b00;
        end
        else
        begin
            port1_out_q <= port1_latch_q | {tout_all[0], 7'h00};
            port1_oe_q  <= ~port1_dir_q;
            port3_out_q <= port3_latch_q | {tout_all[1], 3'h0};
            port3_oe_q  <= ~port3_dir_q;
            match_irq_q <= irq_all;
        end
    end

endmodule // tmec_top

//--- bench/tmec_props.sv
// assertion checker watching the timer/event counter ports
`timescale 1ns/1ps
`include "tmec_regs.vh"
module tmec_props
(
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // apb slave
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [17:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // pins and requests
    input logic [7:0]  port1_oe_q,
    input logic [3:0]  port3_oe_q,
    input logic [1:0]  match_irq_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // -----------------------------------------------------------------
    // helper decode
    // -----------------------------------------------------------------
    logic [15:0] idx;
    logic [7:0]  wd;
    logic        mapped;
    logic        dir_wr;
    assign idx    = paddr[17:2];
    assign wd     = pwdata[7:0];
    assign dir_wr = psel && penable && pready && pwrite
                    && idx == `TMEC_IDX_PORT1_DIR;
    assign mapped = idx inside {`TMEC_IDX_PORT3_DIR, `TMEC_IDX_MODE1,
        `TMEC_IDX_MODE0, `TMEC_IDX_CLKSEL0, `TMEC_IDX_CLKSEL1,
        `TMEC_IDX_PORT1_DIR, `TMEC_IDX_PORT1_LATCH, `TMEC_IDX_PORT3_LATCH,
        `TMEC_IDX_CMP0, `TMEC_IDX_CMP1, `TMEC_IDX_COUNT0, `TMEC_IDX_COUNT1};

    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_no_wait_a: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    unmapped_error_a: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside answer");
    irq0_pulse_a: assert property (match_irq_q[0] |=> !match_irq_q[0])
        else $error("channel 0 request longer than one cycle");
    irq1_pulse_a: assert property (match_irq_q[1] |=> !match_irq_q[1])
        else $error("channel 1 request longer than one cycle");
    dir_drive_a: assert property ($past(dir_wr, 2) |-> port1_oe_q == ~$past(wd, 2))
        else $error("pin drive does not follow direction");
    dir_hold_a: assert property (!$past(dir_wr) && !$past(dir_wr, 2) |-> $stable(port1_oe_q))
        else $error("pin drive changed without direction write");
    reset_pins_a: assert property ($rose(presetn) |-> port1_oe_q == 8'h00 && port3_oe_q == 4'h0 && match_irq_q == 2'b00)
        else $error("outputs not idle after reset");

    irq0_seen_c: cover property (match_irq_q[0]);
    irq1_seen_c: cover property (match_irq_q[1]);
    refused_c:   cover property (pslverr);
endmodule // tmec_props

bind tmec_top tmec_props u_props (.*);

//--- bench/tmec_pins.sv
// pin world model: event pulse sources and the shared timer pins
`timescale 1ns/1ps
module tmec_pins
(
    // clock
    input  logic       pclk,
    // device pin drive
    input  logic [7:0] port1_out_q,
    input  logic [7:0] port1_oe_q,
    input  logic [3:0] port3_out_q,
    input  logic [3:0] port3_oe_q,
    // pin levels back to the device
    output logic [7:0]      port1_in,
    output logic [3:0]      port3_in
);
    logic [1:0] src;
    logic [7:0] noise;
    initial
    begin
        src   = 2'b11;
        noise = 8'h5a;
    end
    // undriven lines other than the two shared pins toggle so a stale level is never mistaken for data
    always @(posedge pclk)
        noise <= ~noise;
    // driven pins show the device level, else the external source
    assign port1_in = (port1_oe_q & port1_out_q)
                    | (~port1_oe_q & {src[0], noise[6:0]});
    assign port3_in = (port3_oe_q & port3_out_q)
                    | (~port3_oe_q & {src[1], noise[2:0]});

    // n low pulses: one falling and one rising edge each
    task automatic pulse(input int ch, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            src[ch] <= 1'b0;
            repeat (4) @(posedge pclk);
            src[ch] <= 1'b1;
            repeat (6) @(posedge pclk);
        end
    endtask
endmodule // tmec_pins

//--- bench/tmec_top_tb_top.sv
// self-checking bench for the two timer/event counters
`timescale 1ns/1ps
`include "tmec_regs.vh"
module tmec_top_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  port1_in;
    logic [7:0]  port1_out_q;
    logic [7:0]  port1_oe_q;
    logic [3:0]  port3_in;
    logic [3:0]  port3_out_q;
    logic [3:0]  port3_oe_q;
    logic [1:0]  match_irq_q;
    logic [32:0] expq[$];
    logic [15:0] mode_i[2];
    logic [15:0] sel_i[2];
    logic [15:0] cmp_i[2];
    logic [15:0] cnt_i[2];
    logic [8:0]  steps[10];
    int          divs[8];
    int          irq_n[2];
    int          fails;
    int          checks;
    int          c;
    integer      seed;
    integer      r;

    tmec_top dut (.*);
    tmec_pins u_pins (.*);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // -----------------------------------------------------------------
    // checking and bus tasks
    // -----------------------------------------------------------------
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] want);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic stall();
        check(33'h0, 33'h1);
        results();
    endtask
    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [7:0] d);
        int k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++k < 20);
        if (k >= 20)
            stall();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] d,
                      input logic err);
        expq.push_back({err, 24'h00_0000, d});
        apb(1'b0, idx, 8'h00);
    endtask
    task automatic pin(input logic want);
        repeat (3) @(negedge pclk);
        check({32'h0, port1_out_q[7]}, {32'h0, want});
    endtask
    task automatic irq_gap(input int ch, input int lim, output int n);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (match_irq_q[ch] !== 1'b1 && n < lim);
        if (n >= lim)
            stall();
    endtask
    task automatic interval(input logic [2:0] sel, input logic [7:0] cmp);
        int   want;
        logic p;
        want = (cmp + 1) * divs[sel];
        apb(1'b1, `TMEC_IDX_MODE0, 8'h03);
        apb(1'b1, `TMEC_IDX_CLKSEL0, {5'h00, sel});
        apb(1'b1, `TMEC_IDX_CMP0, cmp);
        rd(`TMEC_IDX_COUNT0, 8'h00, 1'b0);
        apb(1'b1, `TMEC_IDX_MODE0, 8'h83);
        irq_gap(0, 2 * want + 40, c);
        p = port1_out_q[7];
        irq_gap(0, want + 8, c);
        check({1'b0, c}, {1'b0, want});
        check({32'h0, port1_out_q[7]}, {32'h0, ~p});
        $display("test interval sel %0d cmp %h done", sel, cmp);
    endtask

    // -----------------------------------------------------------------
    // result watchers
    // -----------------------------------------------------------------
    always @(posedge pclk)
    begin
        if (match_irq_q[0] === 1'b1)
            irq_n[0]++;
        if (match_irq_q[1] === 1'b1)
            irq_n[1]++;
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            if (expq.size() == 0)
                stall();
            check({pslverr, prdata}, expq.pop_front());
        end
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        seed = 32'h048f_1e13;
        {fails, checks, irq_n[0], irq_n[1]} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        mode_i = '{`TMEC_IDX_MODE0, `TMEC_IDX_MODE1};
        sel_i  = '{`TMEC_IDX_CLKSEL0, `TMEC_IDX_CLKSEL1};
        cmp_i  = '{`TMEC_IDX_CMP0, `TMEC_IDX_CMP1};
        cnt_i  = '{`TMEC_IDX_COUNT0, `TMEC_IDX_COUNT1};
        divs   = '{0, 0, 1, 2, 4, 64, 256, 8192};
        // {mode written, pin level expected}
        steps  = '{9'h002, 9'h013, 9'h00a, 9'h010, 9'h003,
                   9'h00a, 9'h082, 9'h087, 9'h092, 9'h002};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TMEC_IDX_MODE0, 8'h00, 1'b0);
        rd(`TMEC_IDX_MODE1, 8'h00, 1'b0);
        rd(`TMEC_IDX_PORT1_DIR, 8'hff, 1'b0);
        rd(`TMEC_IDX_PORT3_DIR, 8'hff, 1'b0);
        rd(16'h0000, 8'h00, 1'b1);
        apb(1'b1, `TMEC_IDX_MODE1, 8'h7f);
        rd(`TMEC_IDX_MODE1, 8'h43, 1'b0);
        apb(1'b1, `TMEC_IDX_MODE1, 8'h00);
        apb(1'b1, `TMEC_IDX_COUNT0, 8'h55);
        rd(`TMEC_IDX_COUNT0, 8'h00, 1'b0);
        apb(1'b1, `TMEC_IDX_PORT3_DIR, 8'h00);
        rd(`TMEC_IDX_PORT3_DIR, 8'hf0, 1'b0);
        apb(1'b1, `TMEC_IDX_PORT3_DIR, 8'hff);
        apb(1'b1, `TMEC_IDX_PORT1_DIR, 8'h7f);
        $display("test registers done");
        // pin reacts with the counter stopped throughout
        foreach (steps[i])
        begin
            apb(1'b1, `TMEC_IDX_MODE0, steps[i][8:1]);
            pin(steps[i][0]);
        end
        $display("test output control done");
        r = $random(seed);
        interval(3'h2, 8'h01);
        interval(3'h2, 8'hff);
        interval(3'h2, r[7:0] | 8'h01);
        for (int s = 3; s < 8; s++)
            interval(s[2:0], 8'h01);
        apb(1'b1, `TMEC_IDX_MODE0, 8'h03);
        apb(1'b1, `TMEC_IDX_MODE0, 8'h41);
        apb(1'b1, `TMEC_IDX_CLKSEL0, 8'h02);
        apb(1'b1, `TMEC_IDX_CMP0, 8'h40);
        apb(1'b1, `TMEC_IDX_MODE0, 8'hc1);
        repeat (300) @(negedge pclk);
        irq_n[0] = 0;
        c = 0;
        repeat (512)
        begin
            @(negedge pclk);
            c += port1_out_q[7];
        end
        check({1'b0, c}, 33'd128);
        check({1'b0, irq_n[0]}, 33'd0);
        apb(1'b1, `TMEC_IDX_MODE0, 8'h41);
        pin(1'b0);
        $display("test pwm done");
        apb(1'b1, `TMEC_IDX_PORT1_DIR, 8'hff);
        for (int ch = 0; ch < 2; ch++)
        begin
            apb(1'b1, mode_i[ch], 8'h00);
            apb(1'b1, sel_i[ch], (ch == 0) ? 8'h01 : 8'h00);
            apb(1'b1, cmp_i[ch], 8'h03);
            apb(1'b1, mode_i[ch], 8'h80);
            irq_n[ch] = 0;
            u_pins.pulse(ch, 3);
            rd(cnt_i[ch], 8'h03, 1'b0);
            u_pins.pulse(ch, 1);
            check({1'b0, irq_n[ch]}, 33'd1);
            rd(cnt_i[ch], 8'h00, 1'b0);
            u_pins.pulse(ch, 4);
            check({1'b0, irq_n[ch]}, 33'd2);
            $display("test event channel %0d done", ch);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TMEC_IDX_MODE1, 8'h00, 1'b0);
        rd(`TMEC_IDX_PORT1_DIR, 8'hff, 1'b0);
        $display("test second reset done");
        results();
    end
endmodule // tmec_top_tb_top
